/* src/rpf_pkg.sv */
package rpf_pkg;
   // ------------------------------------------------------------
   // Register map (word addresses, one byte-wide register per word)
   // ------------------------------------------------------------
   localparam logic [3:0] RPF_CTRL_IDX = 4'h4;
   localparam logic [3:0] RPF_WIDTH_IDX = 4'h5;
   localparam logic [5:0] RPF_CTRL_ADDR = {2'b00, RPF_CTRL_IDX};
   localparam logic [5:0] RPF_WIDTH_ADDR = {2'b00, RPF_WIDTH_IDX};
   localparam logic [5:0] RPF_MODE_ADDR = 6'h20;
   localparam logic [5:0] RPF_STAT_ADDR = 6'h24;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int RPF_RW_SEL_LSB = 0;
   localparam int RPF_STOP_SEL_BIT = 2;
   localparam int RPF_WIDTH_BITS = 5;
   localparam logic [2:0] RPF_CTRL_RST = 3'h0;
   localparam logic [4:0] RPF_WIDTH_RST = 5'h00;

   // Run/wait filter source codes
   localparam logic [1:0] RPF_RW_NONE = 2'h0;
   localparam logic [1:0] RPF_RW_BUS = 2'h1;
   localparam logic [1:0] RPF_RW_OSC = 2'h2;

   // Power mode as seen by the filter
   typedef enum logic [1:0] {
      RPF_MODE_RUN,
      RPF_MODE_WAIT,
      RPF_MODE_STOP,
      RPF_MODE_LEAK
   } rpf_mode_t;

   // Low-power oscillator filter count in its own clock ticks
   localparam int RPF_OSC_COUNT = 3;
endpackage

/* src/rpf_reset_pin_filter.sv */
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
module rpf_reset_pin_filter
   import rpf_pkg::*;
#(
   parameter int OSC_COUNT = RPF_OSC_COUNT
) (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic por_n,
   // Avalon-MM slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Power mode and oscillator tick
   input wire logic [1:0] power_mode,
   input wire logic low_power_osc_clock,
   // Reset pin in, filtered level out (active low)
   input wire logic reset_pin_n,
   output logic filtered_reset_n
);

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic [2:0] ctrl_ff;
   logic [4:0] width_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic stop_mode;
   logic [1:0] active_sel;
   wire access = (avs_read | avs_write) & ~ack_ff;
   wire hit_ctrl = avs_address == RPF_CTRL_ADDR;
   wire hit_width = avs_address == RPF_WIDTH_ADDR;
   wire hit_stat = avs_address == RPF_STAT_ADDR;
   // Writes land on the edge that sees waitrequest low, as the master expects
   wire commit = (avs_read | avs_write) & ack_ff;
   wire wr_ctrl = commit & avs_write & hit_ctrl & avs_byteenable[0];
   wire wr_width = commit & avs_write & hit_width & avs_byteenable[0];

   // One wait state per access; answer on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata = rdata_ff;

   // Unused high bits are zero padding, writes to them are dropped
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit_ctrl) begin
         nxt_rdata = {29'h0, ctrl_ff};
      end else if (hit_width) begin
         nxt_rdata = {27'h0, width_ff};
      end else if (hit_stat) begin
         nxt_rdata = {28'h0, stop_mode, active_sel, filtered_reset_n};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= access;
         if (access & avs_read) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // Settings live on the power-on reset only, so warm resets keep them
   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         ctrl_ff <= RPF_CTRL_RST;
         width_ff <= RPF_WIDTH_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= avs_writedata[2:0];
         end
         if (wr_width) begin
            width_ff <= avs_writedata[RPF_WIDTH_BITS-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   assign stop_mode = power_mode[1];
   wire [1:0] rw_sel = ctrl_ff[RPF_RW_SEL_LSB+1:RPF_RW_SEL_LSB];
   // Stop modes honour only the stop bit; reserved run code filters nothing
   assign active_sel = stop_mode ? (ctrl_ff[RPF_STOP_SEL_BIT] ? RPF_RW_OSC : RPF_RW_NONE)
                                 : ((rw_sel == RPF_RW_BUS || rw_sel == RPF_RW_OSC) ? rw_sel
                                    : RPF_RW_NONE);
   wire bus_on = active_sel == RPF_RW_BUS;
   wire osc_on = active_sel == RPF_RW_OSC;

   // ------------------------------------------------------------
   // Pin and oscillator synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_sync_ff;
   logic [2:0] osc_sync_ff;
   logic osc_lvl_ff;
   // Oscillator level is taken only once stages two and three agree
   wire osc_agree = osc_sync_ff[1] == osc_sync_ff[2];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_ff <= 3'h7;
         osc_sync_ff <= 3'h0;
         osc_lvl_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], reset_pin_n};
         osc_sync_ff <= {osc_sync_ff[1:0], low_power_osc_clock};
         if (osc_agree) begin
            osc_lvl_ff <= osc_sync_ff[2];
         end
      end
   end
   // Level counts only once stages two and three agree
   wire pin_agree = pin_sync_ff[1] == pin_sync_ff[2];
   wire pin_lvl = pin_sync_ff[2];
   // One tick per settled rising edge; an oscillator already high at reset release
   // gives one early tick, which only shortens the first filter window
   wire osc_tick = osc_agree & osc_sync_ff[2] & ~osc_lvl_ff;

   // ------------------------------------------------------------
   // Filters
   // ------------------------------------------------------------
   logic [5:0] bus_cnt_ff;
   logic [7:0] osc_cnt_ff;
   logic out_ff;
   wire [5:0] bus_target = {1'b0, width_ff} + 6'h01;
   wire differs = pin_agree & (pin_lvl != out_ff);

   // Counters restart whenever the pin level matches the output again, so only a steady level passes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_cnt_ff <= 6'h00;
         osc_cnt_ff <= 8'h00;
         out_ff <= 1'b1;
      end else begin
         if (!bus_on || stop_mode || !differs) begin
            bus_cnt_ff <= 6'h00;
         end else if (bus_cnt_ff + 6'h01 >= bus_target) begin
            bus_cnt_ff <= 6'h00;
         end else begin
            bus_cnt_ff <= bus_cnt_ff + 6'h01;
         end
         if (!osc_on || !differs) begin
            osc_cnt_ff <= 8'h00;
         end else if (osc_tick) begin
            osc_cnt_ff <= (osc_cnt_ff + 8'h01 >= 8'(OSC_COUNT)) ? 8'h00 : osc_cnt_ff + 8'h01;
         end
         if (active_sel == RPF_RW_NONE && pin_agree) begin
            out_ff <= pin_lvl;
         end else if (bus_on && differs && bus_cnt_ff + 6'h01 >= bus_target) begin
            out_ff <= pin_lvl;
         end else if (osc_on && differs && osc_tick && osc_cnt_ff + 8'h01 >= 8'(OSC_COUNT)) begin
            out_ff <= pin_lvl;
         end
      end
   end
   assign filtered_reset_n = out_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Named steps: a filter that was running is parked by stop or switched off
   sequence s_stop_entry;
      !stop_mode ##1 stop_mode;
   endsequence
   sequence s_osc_drop;
      osc_on ##1 !osc_on;
   endsequence

   a_bus_filter_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (bus_on && !stop_mode && $changed(out_ff)) |-> $past(bus_cnt_ff) + 6'h01 >= bus_target
         || $past(active_sel) != RPF_RW_BUS)
      else $error("bus filter passed a change early");
   a_bus_clear_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(stop_mode) |-> bus_cnt_ff == 6'h00)
      else $error("bus filter state kept in stop");
   a_stop_entry_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_stop_entry |=> bus_cnt_ff == 6'h00)
      else $error("bus filter state kept after entering stop");
   a_osc_clear_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !$past(osc_on) |-> osc_cnt_ff == 8'h00)
      else $error("oscillator filter state kept while off");
   a_osc_drop_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_osc_drop |=> osc_cnt_ff == 8'h00)
      else $error("oscillator filter state kept after disable");
   a_stop_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stop_mode |-> active_sel != RPF_RW_BUS)
      else $error("bus filter used in stop");
   a_rw_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!stop_mode && rw_sel == 2'h3) |-> active_sel == RPF_RW_NONE)
      else $error("reserved code enabled a filter");
   a_pass_through: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (active_sel == RPF_RW_NONE && pin_agree) |=> out_ff == $past(pin_lvl))
      else $error("unfiltered pin not passed");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ack_ff && $past(avs_read) && ($past(hit_ctrl) || $past(hit_width)))
         |-> avs_readdata[31:5] == 27'h0)
      else $error("reserved bits read nonzero");
   a_ctrl_kept: assert property (@(posedge sys_clk) disable iff (!por_n)
      !wr_ctrl |=> $stable(ctrl_ff))
      else $error("control bits changed without a write");
   a_width_kept: assert property (@(posedge sys_clk) disable iff (!por_n)
      !wr_width |=> $stable(width_ff))
      else $error("width changed without a write");
   a_width_write: assert property (@(posedge sys_clk) disable iff (!por_n)
      wr_width |=> width_ff == 5'($past(avs_writedata)))
      else $error("width write lost");
endmodule

/* testbench/rpf_pin_driver.sv */
`timescale 1ns/10ps
module rpf_pin_driver (
   // Clock
   input wire logic sys_clk,
   // Board reset pin, pulled up while nobody pushes it
   output logic reset_pin_n
);
   initial reset_pin_n = 1'b1;
   // Press the pin for len cycles; the pull-up brings it back high
   task automatic pulse(input int len);
      @(posedge sys_clk) reset_pin_n <= 1'b0;
      repeat (len) @(posedge sys_clk);
      reset_pin_n <= 1'b1;
   endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import rpf_pkg::*;
   // ------------------------------------------------------------
   // Signals and design
   // ------------------------------------------------------------
   logic sys_clk, rst_n, por_n, avs_read, avs_write, osc, avs_waitrequest;
   logic pin_n, filt_n, seen_low;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [1:0] power_mode;
   logic [7:0] lfsr = 8'h06;
   logic [7:0] r;
   int mismatches = 0, n_compared = 0;
   logic [2:0] m_ctrl [6] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h5, 3'h6};
   logic [1:0] m_mode [6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1};
   logic m_pass [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   rpf_reset_pin_filter #(.OSC_COUNT(3)) rpf_reset_pin_filter_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .power_mode(power_mode), .low_power_osc_clock(osc), .reset_pin_n(pin_n),
      .filtered_reset_n(filt_n));
   rpf_pin_driver rpf_pin_driver_inst (.sys_clk(sys_clk), .reset_pin_n(pin_n));
   // Clocks: oscillator is slow and unrelated in phase to the bus clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      osc = 1'b0;
      forever #51.3 osc = ~osc;
   end
   // Latch any low seen on the filtered output
   always @(posedge sys_clk) if (filt_n === 1'b0) seen_low <= 1'b1;
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(what, exp, rdat);
   endtask
   // Press the pin for len cycles and see whether the filter let it through
   task automatic filt(input int len, input logic pass, input string what);
      @(posedge sys_clk) seen_low <= 1'b0;
      rpf_pin_driver_inst.pulse(len);
      repeat (len + 80) @(posedge sys_clk);
      check(what, {31'h0, pass}, {31'h0, seen_low});
   endtask
   task automatic conclude;
      $display("mismatches %0d n_compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      conclude;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {por_n, rst_n, avs_read, avs_write, seen_low} = 5'h00;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      power_mode = RPF_MODE_RUN;
      repeat (2) @(posedge sys_clk);
      por_n <= 1'b1;
      rst_n <= 1'b1;
      rchk(RPF_CTRL_ADDR, 32'h0, "ctrl por");
      rchk(RPF_WIDTH_ADDR, 32'h0, "width por");
      bus(1'b1, RPF_CTRL_ADDR, 32'hFFFF_FFFF);
      rchk(RPF_CTRL_ADDR, 32'h7, "ctrl spare bits");
      bus(1'b1, RPF_WIDTH_ADDR, 32'hFFFF_FFFF);
      rchk(RPF_WIDTH_ADDR, 32'h1F, "width spare bits");
      rchk(RPF_MODE_ADDR, 32'h0, "unmapped");
      @(posedge sys_clk) rst_n <= 1'b0;
      @(posedge sys_clk) rst_n <= 1'b1;
      rchk(RPF_CTRL_ADDR, 32'h7, "ctrl warm");
      rchk(RPF_WIDTH_ADDR, 32'h1F, "width warm");
      rchk(RPF_STAT_ADDR, 32'h1, "status idle");
      // Bus filter: the sync stages eat one cycle of every press, so a press of
      // code length is eaten and one two cycles longer passes; code 0 gets one cycle
      bus(1'b1, RPF_CTRL_ADDR, 32'h1);
      for (int i = 0; i < 6; i++) begin
         lfsr = nxt(lfsr);
         r = (i == 0) ? 8'hFF : ((i == 1) ? 8'hE0 : lfsr);
         bus(1'b1, RPF_WIDTH_ADDR, {24'h0, r});
         rchk(RPF_WIDTH_ADDR, {27'h0, r[4:0]}, "width");
         filt(int'(r[4:0]) + int'(r[4:0] == 5'h00), 1'b0, "short pulse");
         filt(int'(r[4:0]) + 2, 1'b1, "long pulse");
      end
      // Two-cycle press, the shortest that passes the synchroniser unfiltered
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, RPF_CTRL_ADDR, {29'h0, m_ctrl[i]});
         power_mode <= m_mode[i];
         filt(2, m_pass[i], "mode pulse");
         power_mode <= RPF_MODE_RUN;
      end
      // Oscillator filter in run mode lets a long press through after its ticks
      bus(1'b1, RPF_CTRL_ADDR, 32'h2);
      filt(200, 1'b1, "osc long press");
      // Back from low-leakage stop: software rewrites the stop select first
      power_mode <= RPF_MODE_LEAK;
      @(posedge sys_clk) power_mode <= RPF_MODE_RUN;
      bus(1'b1, RPF_CTRL_ADDR, 32'h4);
      rchk(RPF_CTRL_ADDR, 32'h4, "stop select rewrite");
      @(posedge sys_clk) por_n <= 1'b0;
      @(posedge sys_clk) por_n <= 1'b1;
      rchk(RPF_CTRL_ADDR, 32'h0, "ctrl por again");
      rchk(RPF_WIDTH_ADDR, 32'h0, "width por again");
      conclude;
   end
endmodule
